// File: core/wait_bank_pkg.sv
// Shared constants for the external wait-state and bank-switch block
package wait_bank_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] WAIT_STATE_CONFIG_IDX = 8'h28;
  localparam logic [7:0] BANK_SWITCH_CONTROL_IDX = 8'h29;
  localparam logic [7:0] WAIT_MULTIPLIER_CONTROL_IDX = 8'h2B;

  // Field positions in wait_state_config
  localparam int EXT_PROG_SEL_BIT = 15;
  localparam int IO_LSB = 12;
  localparam int DATA_HI_LSB = 9;
  localparam int DATA_LO_LSB = 6;
  localparam int PROG_HI_LSB = 3;
  localparam int PROG_LO_LSB = 0;
  localparam int BASE_W = 3;

  // Field positions in bank_switch_control
  localparam int CONSECUTIVE_BIT = 15;
  localparam int DIV_LSB = 13;
  localparam int INT_ACK_OFF_BIT = 12;
  localparam int HOST_KEEPER_BIT = 2;
  localparam int DATA_KEEPER_BIT = 1;

  // Field position in wait_multiplier_control
  localparam int WSM_BIT = 0;

  // Reset values and writable masks
  localparam logic [15:0] WAIT_STATE_CONFIG_RST = 16'h7FFF;
  localparam logic [15:0] BANK_SWITCH_CONTROL_RST = 16'hF000;
  localparam logic [15:0] BANK_SWITCH_CONTROL_WMASK = 16'hF006;
  localparam logic [15:0] WAIT_MULTIPLIER_CONTROL_RST = 16'h0000;
  localparam logic [15:0] WAIT_MULTIPLIER_CONTROL_WMASK = 16'h0001;

  // Address geometry of the external spaces
  localparam int PROG_ADDR_W = 23;
  localparam int BANK_BIT = 15;
  localparam int EXT_PROG_SPLIT_BIT = 22;

  // Address spaces of an external access
  typedef enum logic [1:0] {
    SPACE_PROG = 2'b00,
    SPACE_DATA = 2'b01,
    SPACE_IO = 2'b10
  } space_t;

  // HTRANS encodings used by the slave
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage : wait_bank_pkg

// File: core/clock_out_divider.sv
// Divider that makes the slow clock-output level and its rate enable
`timescale 1ns/1ps
module clock_out_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] divide,
  output logic tick,
  output logic clk_level
);
  import wait_bank_pkg::*;

  logic [1:0] cnt_q; // Position within one output period
  logic [1:0] cnt_d;
  logic [2:0] half; // Cycles spent high in one period
  logic level_d;

  // Period is divide+1 cycles; wrap at the field value
  assign cnt_d = (cnt_q >= divide) ? 2'h0 : cnt_q + 2'h1;
  // High for the first half, rounded up; divide-by-one stays high
  assign half = 3'((3'(divide) + 3'h2) >> 1);
  assign level_d = ({1'b0, cnt_d} < half) || (divide == 2'h0);
  assign tick = (cnt_q == 2'h0);

  // Counter and registered output level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'h0;
      clk_level <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      clk_level <= level_d;
    end
  end

endmodule : clock_out_divider

// File: core/external_wait_state_bank_switch.sv
// Wait-state generator and bank-switch cycle insertion with an AHB-Lite register slave
// Summary of operation
// RULE_01: I/O accesses use bits 14-12 count
// RULE_02: Data 8000-FFFFh uses bits 11-9 count
// RULE_03: Data 0000-7FFFh uses bits 8-6 count
// RULE_04: Upper program region uses bits 5-3
// RULE_05: Lower program region uses bits 2-0
// RULE_06: Bit 15 moves the program region split
// RULE_07: Multiplier bit doubles every base count
// RULE_08: Multiplier register keeps bits 15-1 zero
// RULE_09: Reset gives seven waits everywhere
// RULE_10: Crossing a 32K bank adds one cycle
// RULE_11: Bank control register at index 0029h
// RULE_12: Wait configuration register at index 0028h
// RULE_13: Multiplier register at index 002Bh
// RULE_14: Consecutive mode frames reads with extra cycles
// RULE_15: Clock output divides by field plus one
// RULE_16: Stall each access for selected waits
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module external_wait_state_bank_switch #(
  parameter int ADDR_W = wait_bank_pkg::PROG_ADDR_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External access request from the core
  input wire logic acc_req,
  input wire wait_bank_pkg::space_t acc_space,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_read,
  output logic acc_ready,
  output logic acc_done,
  output logic bank_cycle,
  output logic ext_strobe,
  output logic trail_cycle,
  // Pin-side controls
  output logic clock_output_pin,
  output logic clock_output_tick,
  output logic interrupt_ack_output_off,
  output logic host_data_bus_keeper,
  output logic data_bus_keeper
);
  import wait_bank_pkg::*;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BANK = 2'b01,
    ST_STROBE = 2'b10,
    ST_TRAIL = 2'b11
  } acc_state_t;

  // Software-visible registers
  logic [15:0] wait_state_config_q;
  logic [15:0] bank_switch_control_q;
  logic [15:0] wait_multiplier_control_q;

  // Bus data-phase bookkeeping
  logic wr_pend_q; // Write data phase under way
  logic rd_pend_q; // Read data phase under way
  logic rd_wait_q; // Read wait cycle already spent
  logic [7:0] idx_q; // Register index captured in address phase
  logic [31:0] hrdata_q;

  // Sequencer state
  acc_state_t state_q;
  acc_state_t state_d;
  logic [3:0] wait_cnt_q; // Wait cycles still to run in the strobe
  logic [3:0] wait_cnt_d;
  logic trail_q; // Trailing cycle owed by this access
  logic last_valid_q; // A program or data access has been seen
  space_t last_space_q; // Space of the last program or data access
  logic [ADDR_W-1-BANK_BIT:0] last_bank_q; // Bank number of that access

  // Address-phase decode
  wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire [7:0] idx_a = haddr[9:2];
  wire word_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == '0);

  // Field selection helpers
  // The extended select only moves the program split; data and I/O ignore it
  wire ext_sel = wait_state_config_q[EXT_PROG_SEL_BIT]; // [RULE_06]
  wire wsm = wait_multiplier_control_q[WSM_BIT];
  wire consecutive = bank_switch_control_q[CONSECUTIVE_BIT];

  // Pick the base count for a space and address
  function automatic logic [2:0] base_for(input space_t sp, input logic [ADDR_W-1:0] a,
                                          input logic [15:0] cfg, input logic x);
    logic hi;
    hi = 1'b0;
    base_for = cfg[PROG_LO_LSB +: BASE_W];
    unique case (sp)
      SPACE_IO: begin
        base_for = cfg[IO_LSB +: BASE_W]; // [RULE_01]
      end
      SPACE_DATA: begin
        if (a[BANK_BIT]) begin
          base_for = cfg[DATA_HI_LSB +: BASE_W]; // [RULE_02]
        end else begin
          base_for = cfg[DATA_LO_LSB +: BASE_W]; // [RULE_03]
        end
      end
      SPACE_PROG: begin
        // Extended mode splits at the top address bit, else within each 64K page
        hi = x ? a[EXT_PROG_SPLIT_BIT] : a[BANK_BIT]; // [RULE_06]
        if (hi) begin
          base_for = cfg[PROG_HI_LSB +: BASE_W]; // [RULE_04]
        end else begin
          base_for = cfg[PROG_LO_LSB +: BASE_W]; // [RULE_05]
        end
      end
      default: begin
        base_for = cfg[IO_LSB +: BASE_W];
      end
    endcase
  endfunction : base_for

  // Register read mux, decoding used by the read path
  function automatic logic [15:0] reg_read(input logic [7:0] idx, input logic [15:0] ws,
                                           input logic [15:0] bs, input logic [15:0] wm);
    unique case (idx)
      WAIT_STATE_CONFIG_IDX: reg_read = ws; // [RULE_12]
      BANK_SWITCH_CONTROL_IDX: reg_read = bs; // [RULE_11]
      WAIT_MULTIPLIER_CONTROL_IDX: reg_read = wm; // [RULE_13]
      default: reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  // Wait count for the incoming access
  wire [2:0] base_cnt = base_for(acc_space, acc_addr, wait_state_config_q, ext_sel); // [RULE_16]
  // Fourteen waits at most, so the doubled count still fits four bits
  wire [3:0] waits = wsm ? {base_cnt, 1'b0} : {1'b0, base_cnt}; // [RULE_07]

  // Bank-switch decision for program and data space
  wire pd_space = (acc_space == SPACE_PROG) || (acc_space == SPACE_DATA);
  wire [ADDR_W-1-BANK_BIT:0] bank_a = acc_addr[ADDR_W-1:BANK_BIT];
  wire bank_cross = pd_space && last_valid_q &&
                    ((last_space_q != acc_space) || (last_bank_q != bank_a)); // [RULE_10]
  // Consecutive mode frames every read with a starting and trailing cycle
  // Writes only get a start cycle on a bank change; reads in this mode always do
  wire need_start = bank_cross || (consecutive && acc_read); // [RULE_14]
  wire need_trail = consecutive && acc_read; // [RULE_14]

  // Request is taken only while idle
  assign acc_ready = (state_q == ST_IDLE);
  wire acc_take = acc_req && acc_ready;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    wait_cnt_d = wait_cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (acc_take) begin
          state_d = need_start ? ST_BANK : ST_STROBE;
          wait_cnt_d = waits; // [RULE_16]
        end
      end
      ST_BANK: begin
        // One inserted cycle while the address moves to the new bank
        state_d = ST_STROBE; // [RULE_10]
      end
      ST_STROBE: begin
        if (wait_cnt_q == 4'h0) begin
          state_d = trail_q ? ST_TRAIL : ST_IDLE;
        end else begin
          wait_cnt_d = wait_cnt_q - 4'h1; // [RULE_16]
        end
      end
      ST_TRAIL: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Phase outputs for the pin logic
  assign bank_cycle = (state_q == ST_BANK);
  assign ext_strobe = (state_q == ST_STROBE);
  assign trail_cycle = (state_q == ST_TRAIL);
  // Done marks the last busy cycle, so the core may ask again on the next one
  assign acc_done = ((state_q == ST_STROBE) && (wait_cnt_q == 4'h0) && !trail_q) ||
                    (state_q == ST_TRAIL);

  // Sequencer registers
  // The trail flag is latched per access, so a mode write mid-access cannot cut it short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      wait_cnt_q <= 4'h0;
      trail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_cnt_q <= wait_cnt_d;
      if (acc_take) begin
        trail_q <= need_trail;
      end
    end
  end

  // Last bank tracker, replaced by every program or data access
  // I/O has its own select line and neither moves nor checks the tracked bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_valid_q <= 1'b0;
      last_space_q <= SPACE_PROG;
      last_bank_q <= '0;
    end else if (acc_take && pd_space) begin
      last_valid_q <= 1'b1;
      last_space_q <= acc_space;
      last_bank_q <= bank_a; // [RULE_10]
    end
  end

  // Bus data-phase tracking; reads spend one wait so data come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      if (hreadyout) begin
        wr_pend_q <= addr_phase && hwrite && word_ok;
        rd_pend_q <= addr_phase && !hwrite;
        rd_wait_q <= 1'b0;
        if (addr_phase) begin
          idx_q <= word_ok ? idx_a : 8'hFF;
        end
      end else begin
        rd_wait_q <= 1'b1;
      end
    end
  end

  // Stall only the first cycle of a read data phase
  // Writes never stall: the register takes hwdata at the end of the data phase
  assign hreadyout = !(rd_pend_q && !rd_wait_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Read data captured after any earlier write has landed
  // The one-cycle read stall buys a registered data path for a small bus cost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q && !rd_wait_q) begin
      hrdata_q <= {16'h0000, reg_read(idx_q, wait_state_config_q, bank_switch_control_q,
                                      wait_multiplier_control_q)};
    end
  end

  // Register writes in the data phase
  // Misaligned or out-of-range addresses carry 8'hFF, which matches no register, as other unmapped indices do not
  // Such a write is dropped quietly; the response stays OKAY
  wire wr_ws = wr_pend_q && (idx_q == WAIT_STATE_CONFIG_IDX); // [RULE_12]
  wire wr_bs = wr_pend_q && (idx_q == BANK_SWITCH_CONTROL_IDX); // [RULE_11]
  wire wr_wm = wr_pend_q && (idx_q == WAIT_MULTIPLIER_CONTROL_IDX); // [RULE_13]

  // Software registers; all base fields reset to their maximum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_state_config_q <= WAIT_STATE_CONFIG_RST; // [RULE_09]
      bank_switch_control_q <= BANK_SWITCH_CONTROL_RST;
      wait_multiplier_control_q <= WAIT_MULTIPLIER_CONTROL_RST;
    end else begin
      if (wr_ws) begin
        wait_state_config_q <= hwdata[15:0];
      end
      if (wr_bs) begin
        // Reserved bits keep reading zero
        bank_switch_control_q <= hwdata[15:0] & BANK_SWITCH_CONTROL_WMASK;
      end
      if (wr_wm) begin
        wait_multiplier_control_q <= hwdata[15:0] & WAIT_MULTIPLIER_CONTROL_WMASK; // [RULE_08]
      end
    end
  end

  // Clock output runs at hclk over field plus one
  // The divider runs freely; a new divide value takes hold within one output period
  clock_out_divider u_clock_out_divider (
    .hclk(hclk),
    .hresetn(hresetn),
    .divide(bank_switch_control_q[DIV_LSB +: 2]), // [RULE_15]
    .tick(clock_output_tick),
    .clk_level(clock_output_pin)
  );

  // Static control outputs straight from the register
  assign interrupt_ack_output_off = bank_switch_control_q[INT_ACK_OFF_BIT];
  assign host_data_bus_keeper = bank_switch_control_q[HOST_KEEPER_BIT];
  assign data_bus_keeper = bank_switch_control_q[DATA_KEEPER_BIT];

endmodule : external_wait_state_bank_switch

// File: dv/wait_bank_properties.sv
// Port-level checks for the wait-state and bank-switch block
`timescale 1ns/1ps
module wait_bank_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic acc_req,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic bank_cycle,
  input wire logic ext_strobe,
  input wire logic trail_cycle
);
  import wait_bank_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phases that the slave takes
  sequence rd_take; hsel && hready && htrans == HTRANS_NONSEQ && !hwrite; endsequence
  sequence wr_take; hsel && hready && htrans == HTRANS_NONSEQ && hwrite; endsequence
  // Reads stall one cycle, then complete
  sequence rd_data; !hreadyout ##1 hreadyout; endsequence
  sequence acc_take; acc_req && acc_ready; endsequence
  AST_RD_ONE_WAIT: assert property (rd_take |=> rd_data) else $error("read phase timing wrong");
  AST_WR_NO_WAIT: assert property (wr_take |=> hreadyout) else $error("write stalled");
  AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("error response seen");
  AST_UPPER_ZERO: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_BANK_STROBE: assert property (bank_cycle |=> ext_strobe) else $error("no strobe after bank cycle");
  AST_TRAIL_DONE: assert property (trail_cycle |-> acc_done && !ext_strobe)
    else $error("trail cycle wrong");
  AST_DONE_IDLE: assert property (acc_done |=> acc_ready) else $error("not idle after done");
  AST_BUSY: assert property (bank_cycle || ext_strobe || trail_cycle |-> !acc_ready)
    else $error("idle while busy");
  AST_TAKE_START: assert property (acc_take |=> bank_cycle || ext_strobe)
    else $error("access not started");
  // Worst case is one start, fifteen strobes and one trail
  AST_MAX_LEN: assert property (acc_take |-> ##[1:17] acc_done) else $error("access too long");
endmodule : wait_bank_properties

bind external_wait_state_bank_switch wait_bank_properties i_wait_bank_properties (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .acc_req(acc_req), .acc_ready(acc_ready), .acc_done(acc_done), .bank_cycle(bank_cycle),
  .ext_strobe(ext_strobe), .trail_cycle(trail_cycle));

// File: dv/ext_mem_model.sv
// Far-side memory model that counts strobe cycles per access
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_strobe,
  input wire logic acc_done,
  output logic [4:0] strobe_cnt_q
);
  logic [4:0] run_q; // Strobes seen in the running access
  // Total is latched on done so the bench can read it later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 5'h00;
      strobe_cnt_q <= 5'h00;
    end else if (acc_done) begin
      run_q <= 5'h00;
      strobe_cnt_q <= run_q + {4'h0, ext_strobe};
    end else begin
      run_q <= run_q + {4'h0, ext_strobe};
    end
  end
endmodule : ext_mem_model

// File: dv/testbench.sv
// Self-checking bench for the wait-state and bank-switch block
`timescale 1ns/1ps
module testbench;
  import wait_bank_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, acc_ready, acc_done, dkeep, hkeep, iack;
  logic [31:0] hrdata;
  logic bank_cycle, trail_cycle, ext_strobe, clk_pin, clk_tick; // Phase and clock-output pins
  logic acc_req = 1'b0;
  space_t acc_space = SPACE_IO;
  logic [22:0] acc_addr = 23'h0;
  logic acc_read = 1'b0;
  logic [4:0] strobe_cnt_q; // Strobes of last access, from the model
  logic [15:0] cfg_v = 16'h7FFF; // Expected configuration
  logic mult_v = 1'b0;
  logic consecutive_v = 1'b1;
  logic have_last = 1'b0; // No bank history right after reset
  space_t last_sp;
  logic [7:0] last_bank;
  int failures = 0;
  int compares = 0;
  space_t sp_t[6] = '{SPACE_IO, SPACE_DATA, SPACE_DATA, SPACE_PROG, SPACE_PROG, SPACE_PROG};
  logic [22:0] ad_t[6] = '{23'h000123, 23'h008000, 23'h000010, 23'h408000, 23'h000100, 23'h400000};
  always #10 hclk = ~hclk;
  external_wait_state_bank_switch i_external_wait_state_bank_switch (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_req(acc_req),
    .acc_space(acc_space), .acc_addr(acc_addr), .acc_read(acc_read), .acc_ready(acc_ready),
    .acc_done(acc_done), .bank_cycle(bank_cycle), .ext_strobe(ext_strobe), .trail_cycle(trail_cycle),
    .clock_output_pin(clk_pin), .clock_output_tick(clk_tick), .interrupt_ack_output_off(iack),
    .host_data_bus_keeper(hkeep),
    .data_bus_keeper(dkeep));
  ext_mem_model i_ext_mem_model (.hclk(hclk), .hresetn(hresetn),
    .ext_strobe(ext_strobe), .acc_done(acc_done),
    .strobe_cnt_q(strobe_cnt_q));
  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // One single AHB-Lite transfer; hready is sampled before the edge updates land
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge hclk iff hreadyout);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 16'h0000, v);
    check("register", exp, v);
  endtask : rdc
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
  endtask : wr
  // Base count of the region that an access falls in
  function automatic int base_of(input space_t sp, input logic [22:0] a);
    logic hi;
    hi = cfg_v[15] ? a[22] : a[15];
    case (sp)
      SPACE_IO: return int'(cfg_v[14:12]);
      SPACE_DATA: return int'(a[15] ? cfg_v[11:9] : cfg_v[8:6]);
      default: return int'(hi ? cfg_v[5:3] : cfg_v[2:0]);
    endcase
  endfunction : base_of
  // One core access; the length counts cycles after the taking edge
  task automatic acc(input space_t sp, input logic [22:0] a, input logic rd);
    int n;
    int s;
    int t;
    int w;
    int nb;
    int nt;
    n = 0;
    nb = 0;
    nt = 0;
    t = int'(consecutive_v && rd);
    w = base_of(sp, a) << mult_v;
    s = int'(t == 1 || (have_last && sp != SPACE_IO && (sp != last_sp || a[22:15] != last_bank)));
    if (sp != SPACE_IO) begin
      have_last = 1'b1;
      last_sp = sp;
      last_bank = a[22:15];
    end
    acc_req <= 1'b1;
    acc_space <= sp;
    acc_addr <= a;
    acc_read <= rd;
    @(posedge hclk iff acc_ready);
    acc_req <= 1'b0;
    do begin
      @(posedge hclk);
      n++;
      nb += int'(bank_cycle);
      nt += int'(trail_cycle);
    end while (!acc_done && n < 40);
    @(posedge hclk);
    check("cycles", 1 + w + s + t, n);
    check("bank cycles", s, nb);
    check("trail cycles", t, nt);
    check("strobes", 1 + w, {27'h0, strobe_cnt_q});
  endtask : acc
  // Count clock-output ticks and level changes over twelve cycles
  task automatic clk_chk(input int d);
    int ticks;
    int flips;
    logic prev;
    ticks = 0;
    flips = 0;
    repeat (4) @(posedge hclk);
    prev = clk_pin;
    repeat (12) begin
      @(posedge hclk);
      ticks += int'(clk_tick);
      flips += int'(clk_pin != prev);
      prev = clk_pin;
    end
    check("clock ticks", 12 / (d + 1), ticks);
    check("clock edges", (d == 0) ? 0 : 24 / (d + 1), flips);
  endtask : clk_chk
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(WAIT_STATE_CONFIG_IDX, 32'h7FFF);
    rdc(BANK_SWITCH_CONTROL_IDX, 32'hF000);
    rdc(WAIT_MULTIPLIER_CONTROL_IDX, 32'h0);
    rdc(8'h2A, 32'h0);
    acc(SPACE_IO, 23'h000123, 1'b0);
    acc(SPACE_DATA, 23'h000010, 1'b1);
    $display("test reset_state done");
    wr(WAIT_MULTIPLIER_CONTROL_IDX, 16'hFFFF);
    rdc(WAIT_MULTIPLIER_CONTROL_IDX, 32'h1);
    wr(BANK_SWITCH_CONTROL_IDX, 16'hFFFF);
    rdc(BANK_SWITCH_CONTROL_IDX, 32'hF006);
    check("keepers", 32'h7, {29'h0, iack, hkeep, dkeep});
    // Every divide setting; the last leaves consecutive mode off and the divide field at three
    for (int d = 0; d < 4; d++) begin
      wr(BANK_SWITCH_CONTROL_IDX, 16'(d << 13));
      clk_chk(d);
    end
    consecutive_v = 1'b0;
    $display("test registers done");
    // Distinct base per region, both splits and both multipliers
    for (int m = 0; m < 2; m++) begin
      wr(WAIT_MULTIPLIER_CONTROL_IDX, m[15:0]);
      mult_v = m[0];
      for (int x = 0; x < 2; x++) begin
        cfg_v = x[0] ? 16'h94E5 : 16'h14E5;
        wr(WAIT_STATE_CONFIG_IDX, cfg_v);
        for (int k = 0; k < 6; k++) begin
          acc(sp_t[k], ad_t[k], k[0]);
        end
      end
    end
    $display("test regions done");
    end_sim();
  end
  // Watchdog well beyond the expected run of under four hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    end_sim();
  end
endmodule : testbench
